//--- urab_pkg.sv
package urab_pkg;
	// Core-side register indices of the bridge
	localparam logic [1:0] URAB_IDX_CTRL = 2'h0;
	localparam logic [1:0] URAB_IDX_STAT = 2'h1;
	localparam logic [1:0] URAB_IDX_TARGET = 2'h2;
	localparam logic [1:0] URAB_IDX_FIFO = 2'h3;
	// Bridge control register fields
	localparam int URAB_CTRL_EN_BIT = 0;
	localparam int URAB_CTRL_BURST_BIT = 1;
	localparam int URAB_CTRL_BYTE_BIT = 2;
	localparam int URAB_CTRL_EP_LSB = 8;
	localparam logic [15:0] URAB_CTRL_RESET = 16'h02F0;
	localparam logic [15:0] URAB_CTRL_WMASK = 16'h03F7;
	// Bridge status register fields
	localparam int URAB_STAT_FE_BIT = 0;
	localparam int URAB_STAT_FF_BIT = 1;
	localparam int URAB_STAT_CP_BIT = 2;
	localparam int URAB_STAT_LWR_BIT = 3;
	localparam logic [15:0] URAB_STAT_RESET = 16'h0001;
	// Target address values
	localparam logic [5:0] URAB_TA_OUT_FIFO = 6'h20;
	localparam logic [5:0] URAB_TA_IN_FIFO = 6'h21;
	localparam logic [5:0] URAB_TA_FIFO_BASE = 6'h20;
	// USB register map, byte addresses
	localparam logic [5:0] URAB_A_FUNC_ADDR = 6'h00;
	localparam logic [5:0] URAB_A_POWER = 6'h01;
	localparam logic [5:0] URAB_A_IN_IRQ = 6'h02;
	localparam logic [5:0] URAB_A_OUT_IRQ = 6'h04;
	localparam logic [5:0] URAB_A_IN_IRQ_EN = 6'h06;
	localparam logic [5:0] URAB_A_OUT_IRQ_EN = 6'h08;
	localparam logic [5:0] URAB_A_BUS_IRQ = 6'h0A;
	localparam logic [5:0] URAB_A_BUS_IRQ_EN = 6'h0B;
	localparam logic [5:0] URAB_A_FRAME_LO = 6'h0C;
	localparam logic [5:0] URAB_A_FRAME_HI = 6'h0D;
	localparam logic [5:0] URAB_A_IN_MAXP_LO = 6'h10;
	localparam logic [5:0] URAB_A_IN_MAXP_HI = 6'h11;
	localparam logic [5:0] URAB_A_IN_CSR_LO = 6'h12;
	localparam logic [5:0] URAB_A_IN_CSR_HI = 6'h13;
	localparam logic [5:0] URAB_A_OUT_MAXP_LO = 6'h14;
	localparam logic [5:0] URAB_A_OUT_MAXP_HI = 6'h15;
	localparam logic [5:0] URAB_A_OUT_CSR_LO = 6'h16;
	localparam logic [5:0] URAB_A_OUT_CSR_HI = 6'h17;
	localparam logic [5:0] URAB_A_OUT_CNT_LO = 6'h18;
	localparam logic [5:0] URAB_A_OUT_CNT_HI = 6'h19;
	localparam logic [5:0] URAB_A_INDEXED_LO = 6'h10;
	localparam logic [5:0] URAB_A_INDEXED_HI = 6'h19;
	// Reset values of the power, enable and endpoint-index registers; endpoint count and burst length
	localparam logic [7:0] URAB_POWER_RESET = 8'h20;
	localparam logic [7:0] URAB_IN_IRQ_EN_RESET = 8'h07;
	localparam logic [7:0] URAB_OUT_IRQ_EN_RESET = 8'h06;
	localparam logic [7:0] URAB_BUS_IRQ_EN_RESET = 8'h06;
	localparam logic [1:0] URAB_EP_RESET = 2'h2;
	localparam int URAB_NUM_EP = 3;
	localparam logic [3:0] URAB_BURST_WORDS = 4'h8;
	// Pipeline depth to drain after the last word
	localparam logic [1:0] URAB_PIPE_TAIL = 2'h2;
endpackage : urab_pkg

//--- urab_lane_swap.sv
`timescale 1ns/100ps
`default_nettype none
// Maps a core-side 16-bit access at byte address A to register bytes A and A+1; in byte mode only byte A is written and read.
module urab_lane_swap
	import urab_pkg::*;
(
	input wire logic byte_mode,
	input wire logic [15:0] core_wdata,
	input wire logic [7:0] byte_lo_rdata,
	input wire logic [7:0] byte_hi_rdata,
	output logic [7:0] byte_lo_wdata,
	output logic [7:0] byte_hi_wdata,
	output logic byte_hi_we,
	output logic [15:0] core_rdata
);
	// Core is big-endian: its low-order lane is bits 7:0, carrying byte A
	always_comb begin
		byte_lo_wdata = core_wdata[7:0];
		byte_hi_wdata = core_wdata[15:8];
		byte_hi_we = !byte_mode;
		core_rdata = byte_mode ? {8'h00, byte_lo_rdata} : {byte_hi_rdata, byte_lo_rdata};
	end
endmodule : urab_lane_swap
`default_nettype wire

//--- urab_bridge.sv
// Operation
// - USB registers are reachable by 8-bit or 16-bit access per the byte-width mode bit; FIFO access is always 16-bit.
// - USB registers sit at core-side byte addresses with lanes swapped for the big-endian core.
// - A 16-bit access at address A, odd or even, carries byte A low and byte A+1 high.
// - After reset the endpoint index selects endpoint 2.
// - Map registers reset to zero except the high-speed, endpoint and bus-reset/resume enables, which reset to 1.
// - Writing enable and burst together turns the bridge on in eight-word burst mode.
// - The endpoint index field selects which endpoint the indexed addresses reach.
// - Transfer-in-progress is set while a transfer runs and cleared by hardware when it and its pipeline finish.
`timescale 1ns/100ps
`default_nettype none
module urab_bridge
	import urab_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Bridge registers of the core
	input wire logic [1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Direct USB map access from the core
	input wire logic [5:0] map_addr,
	input wire logic map_wr,
	input wire logic [15:0] map_wdata,
	output logic [15:0] map_rdata,
	// Hardware status from the USB cell
	input wire logic [7:0] in_irq_set,
	input wire logic [7:0] out_irq_set,
	input wire logic [7:0] bus_irq_set,
	input wire logic [10:0] frame_number,
	input wire logic [12:0] out_rx_count,
	// Endpoint FIFO streams
	output logic usb_fifo_wr,
	output logic [15:0] usb_fifo_wdata,
	output logic usb_fifo_rd,
	input wire logic [15:0] usb_fifo_rdata,
	input wire logic usb_fifo_has_data,
	output logic [1:0] usb_fifo_ep
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [5:0] target;
		logic last_word_read_flag;
		logic [3:0] words;
		logic [1:0] tail;
		logic cp;
		logic [15:0] fifo_data;
		logic [7:0] func_addr;
		logic [7:0] power;
		logic [7:0] in_irq;
		logic [7:0] out_irq;
		logic [7:0] in_irq_en;
		logic [7:0] out_irq_en;
		logic [7:0] bus_irq;
		logic [7:0] bus_irq_en;
		logic [URAB_NUM_EP-1:0][10:0] in_maxp;
		logic [URAB_NUM_EP-1:0][15:0] in_csr;
		logic [URAB_NUM_EP-1:0][10:0] out_maxp;
		logic [URAB_NUM_EP-1:0][15:0] out_csr;
		logic pull;
		logic push;
		logic [15:0] rdata;
	} urab_state_t;

	urab_state_t st;
	urab_state_t next_st;
	logic [1:0] ep;
	logic byte_mode;
	logic [7:0] lo_rd;
	logic [7:0] hi_rd;
	logic [7:0] lo_wd;
	logic [7:0] hi_wd;
	logic hi_we;
	logic [15:0] map_rd_swapped;
	logic fifo_wr_hit;
	logic fifo_rd_hit;

	assign ep = st.ctrl[URAB_CTRL_EP_LSB+1:URAB_CTRL_EP_LSB];
	assign byte_mode = st.ctrl[URAB_CTRL_BYTE_BIT];
	assign fifo_wr_hit = reg_wr && reg_addr == URAB_IDX_FIFO && st.ctrl[URAB_CTRL_EN_BIT];
	assign fifo_rd_hit = reg_rd && reg_addr == URAB_IDX_FIFO && st.ctrl[URAB_CTRL_EN_BIT];

	function automatic logic [7:0] map_byte(input urab_state_t s, input logic [1:0] e, input logic [5:0] a,
		input logic [10:0] fn, input logic [12:0] oc);
		logic [7:0] v;
		v = 8'h00;
		// Endpoint 3 is not implemented; its indexed reads return zero, except the OUT count at 0x18-0x19
		unique case (a)
			URAB_A_FUNC_ADDR: v = s.func_addr;
			URAB_A_POWER: v = s.power;
			URAB_A_IN_IRQ: v = s.in_irq;
			URAB_A_OUT_IRQ: v = s.out_irq;
			URAB_A_IN_IRQ_EN: v = s.in_irq_en;
			URAB_A_OUT_IRQ_EN: v = s.out_irq_en;
			URAB_A_BUS_IRQ: v = s.bus_irq;
			URAB_A_BUS_IRQ_EN: v = s.bus_irq_en;
			URAB_A_FRAME_LO: v = fn[7:0];
			URAB_A_FRAME_HI: v = {5'h00, fn[10:8]};
			URAB_A_IN_MAXP_LO: v = (e < 2'h3) ? s.in_maxp[e][7:0] : 8'h00;
			URAB_A_IN_MAXP_HI: v = (e < 2'h3) ? {5'h00, s.in_maxp[e][10:8]} : 8'h00;
			URAB_A_IN_CSR_LO: v = (e < 2'h3) ? s.in_csr[e][7:0] : 8'h00;
			URAB_A_IN_CSR_HI: v = (e < 2'h3 && e != 2'h0) ? s.in_csr[e][15:8] : 8'h00;
			URAB_A_OUT_MAXP_LO: v = (e < 2'h3) ? s.out_maxp[e][7:0] : 8'h00;
			URAB_A_OUT_MAXP_HI: v = (e < 2'h3) ? {5'h00, s.out_maxp[e][10:8]} : 8'h00;
			URAB_A_OUT_CSR_LO: v = (e < 2'h3) ? s.out_csr[e][7:0] : 8'h00;
			URAB_A_OUT_CSR_HI: v = (e < 2'h3) ? s.out_csr[e][15:8] : 8'h00;
			URAB_A_OUT_CNT_LO: v = oc[7:0];
			URAB_A_OUT_CNT_HI: v = {3'h0, oc[12:8]};
			default: v = 8'h00;
		endcase
		return v;
	endfunction : map_byte

	// Write one byte of the map; read-only addresses ignore it
	function automatic urab_state_t map_put(input urab_state_t s, input logic [1:0] e, input logic [5:0] a,
		input logic [7:0] d);
		urab_state_t r;
		r = s;
		unique case (a)
			URAB_A_FUNC_ADDR: r.func_addr = d;
			URAB_A_POWER: r.power = d;
			URAB_A_IN_IRQ_EN: r.in_irq_en = d & 8'h07;
			URAB_A_OUT_IRQ_EN: r.out_irq_en = d & 8'h06;
			URAB_A_BUS_IRQ_EN: r.bus_irq_en = d & 8'h0F;
			URAB_A_IN_MAXP_LO: if (e < 2'h3) r.in_maxp[e][7:0] = d;
			URAB_A_IN_MAXP_HI: if (e < 2'h3) r.in_maxp[e][10:8] = d[2:0];
			URAB_A_IN_CSR_LO: if (e < 2'h3) r.in_csr[e][7:0] = d;
			URAB_A_IN_CSR_HI: if (e < 2'h3 && e != 2'h0) r.in_csr[e][15:8] = d & 8'h98;
			URAB_A_OUT_MAXP_LO: if (e < 2'h3) r.out_maxp[e][7:0] = d;
			URAB_A_OUT_MAXP_HI: if (e < 2'h3) r.out_maxp[e][10:8] = d[2:0];
			URAB_A_OUT_CSR_LO: if (e < 2'h3) r.out_csr[e][7:0] = d & 8'hF3;
			URAB_A_OUT_CSR_HI: if (e < 2'h3) r.out_csr[e][15:8] = d & 8'hB8;
			default: r = s;
		endcase
		return r;
	endfunction : map_put

	always_comb begin
		lo_rd = map_byte(st, ep, map_addr, frame_number, out_rx_count);
		hi_rd = map_byte(st, ep, 6'(map_addr + 6'h01), frame_number, out_rx_count);
	end

	urab_lane_swap urab_lane_swap_i (
		.byte_mode(byte_mode),
		.core_wdata(map_wdata),
		.byte_lo_rdata(lo_rd),
		.byte_hi_rdata(hi_rd),
		.byte_lo_wdata(lo_wd),
		.byte_hi_wdata(hi_wd),
		.byte_hi_we(hi_we),
		.core_rdata(map_rd_swapped)
	);

	always_comb begin
		next_st = st;
		next_st.pull = 1'b0;
		next_st.push = 1'b0;
		// Hardware sets accumulate; map writes never clear these flags
		next_st.in_irq = st.in_irq | (in_irq_set & 8'h07);
		next_st.out_irq = st.out_irq | (out_irq_set & 8'h06);
		next_st.bus_irq = st.bus_irq | (bus_irq_set & 8'h0F);
		if (map_wr) begin
			next_st = map_put(next_st, ep, map_addr, lo_wd);
			if (hi_we) begin
				next_st = map_put(next_st, ep, 6'(map_addr + 6'h01), hi_wd);
			end
		end
		if (reg_wr) begin
			unique case (reg_addr)
				URAB_IDX_CTRL: begin
					// Mode fields only change while the bridge is off
					if (st.ctrl[URAB_CTRL_EN_BIT]) begin
						next_st.ctrl = (st.ctrl & 16'hFFF8) | (reg_wdata & 16'h0301) | (st.ctrl & 16'h0006);
						next_st.ctrl[9:4] = {reg_wdata[9:8], st.ctrl[7:4]};
					end else begin
						next_st.ctrl = reg_wdata & URAB_CTRL_WMASK;
					end
				end
				URAB_IDX_STAT: begin
					if (reg_wdata[URAB_STAT_LWR_BIT]) begin
						next_st.last_word_read_flag = 1'b0;
					end
				end
				URAB_IDX_TARGET: begin
					if (!st.cp) begin
						next_st.target = reg_wdata[5:0];
					end
				end
				URAB_IDX_FIFO: begin
					next_st.fifo_data = reg_wdata;
				end
			endcase
		end
		// Burst sequencing of eight-word packets
		if (fifo_wr_hit || (fifo_rd_hit && st.target == URAB_TA_OUT_FIFO)) begin
			next_st.cp = 1'b1;
			next_st.tail = URAB_PIPE_TAIL;
			if (st.words == URAB_BURST_WORDS - 4'h1 || !st.ctrl[URAB_CTRL_BURST_BIT]) begin
				next_st.words = 4'h0;
				if (fifo_rd_hit) begin
					next_st.last_word_read_flag = 1'b1;
				end
			end else begin
				next_st.words = st.words + 4'h1;
			end
			if (fifo_rd_hit) begin
				next_st.pull = 1'b1;
			end
			// Own push flag, so the packet's last word is not lost when the count wraps
			if (fifo_wr_hit && st.target == URAB_TA_IN_FIFO) begin
				next_st.push = 1'b1;
			end
		end else if (st.cp && st.words == 4'h0) begin
			if (st.tail == 2'h0) begin
				next_st.cp = 1'b0;
			end else begin
				next_st.tail = st.tail - 2'h1;
			end
		end
		if (!st.ctrl[URAB_CTRL_EN_BIT]) begin
			next_st.words = 4'h0;
		end
		if (st.pull) begin
			next_st.rdata = usb_fifo_rdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
			st.ctrl <= URAB_CTRL_RESET;
			st.power <= URAB_POWER_RESET;
			st.in_irq_en <= URAB_IN_IRQ_EN_RESET;
			st.out_irq_en <= URAB_OUT_IRQ_EN_RESET;
			st.bus_irq_en <= URAB_BUS_IRQ_EN_RESET;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		reg_rdata = 16'h0000;
		unique case (reg_addr)
			URAB_IDX_CTRL: reg_rdata = st.ctrl;
			URAB_IDX_STAT: reg_rdata = {12'h000, st.last_word_read_flag, st.cp, 1'b0, !st.cp};
			URAB_IDX_TARGET: reg_rdata = {10'h000, st.target};
			URAB_IDX_FIFO: reg_rdata = st.rdata;
		endcase
	end

	assign map_rdata = map_rd_swapped;
	assign usb_fifo_wr = st.push;
	assign usb_fifo_wdata = st.fifo_data;
	assign usb_fifo_rd = fifo_rd_hit && usb_fifo_has_data;
	assign usb_fifo_ep = ep;

	a_ep_reset: assert property (@(posedge clk_sys) $fell(sys_rst) |-> ep == URAB_EP_RESET)
		else $error("endpoint index not 2 after reset");
	a_cp_set: assert property (@(posedge clk_sys) disable iff (sys_rst) fifo_wr_hit |=> st.cp)
		else $error("cp not set by transfer");
	a_cp_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st.cp && st.words == 4'h0 && !fifo_wr_hit && !fifo_rd_hit)[*3] |=> !st.cp)
		else $error("cp not cleared after pipeline drain");
	a_hse_reset: assert property (@(posedge clk_sys) $fell(sys_rst) |-> st.power == 8'h20)
		else $error("power reset wrong");
	a_en_reset: assert property (@(posedge clk_sys) $fell(sys_rst) |-> st.bus_irq_en == 8'h06)
		else $error("bus enable reset wrong");
	a_burst_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
		reg_wr && reg_addr == URAB_IDX_CTRL && !st.ctrl[0] && reg_wdata[1:0] == 2'h3 |=> st.ctrl[1:0] == 2'h3)
		else $error("enable and burst not taken");
	a_byte_hi: assert property (@(posedge clk_sys) disable iff (sys_rst) byte_mode |-> map_rdata[15:8] == 8'h00)
		else $error("byte mode high lane not zero");
	a_lane_lo: assert property (@(posedge clk_sys) disable iff (sys_rst) map_rdata[7:0] == lo_rd)
		else $error("low lane not byte A");
	a_lane_hi: assert property (@(posedge clk_sys) disable iff (sys_rst) !byte_mode |-> map_rdata[15:8] == hi_rd)
		else $error("high lane not byte A+1");
	c_burst: cover property (@(posedge clk_sys) st.words == 4'h7 ##1 st.words == 4'h0);
	c_lwr: cover property (@(posedge clk_sys) $rose(st.last_word_read_flag));
	c_odd: cover property (@(posedge clk_sys) map_wr && map_addr[0] && !byte_mode);
endmodule : urab_bridge
`default_nettype wire

//--- urab_usb_model.sv
`timescale 1ns/100ps
`default_nettype none
module urab_usb_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic usb_fifo_wr,
	input wire logic [15:0] usb_fifo_wdata,
	input wire logic usb_fifo_rd,
	output logic [15:0] usb_fifo_rdata,
	output logic usb_fifo_has_data,
	output logic [3:0] wr_count,
	output logic [15:0] wr_last,
	output logic [3:0] rd_count
);
	// One packet of eight words waits in the OUT endpoint
	assign usb_fifo_has_data = (rd_count < 4'h8);
	// Registered read port: a pop shows its word in the following cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_count <= 4'h0;
			rd_count <= 4'h0;
			wr_last <= 16'h0000;
			usb_fifo_rdata <= 16'h0000;
		end else begin
			if (usb_fifo_wr) begin
				wr_count <= wr_count + 4'h1;
				wr_last <= usb_fifo_wdata;
			end
			if (usb_fifo_rd && usb_fifo_has_data) begin
				rd_count <= rd_count + 4'h1;
				usb_fifo_rdata <= 16'hA000 + {12'h000, rd_count};
			end
		end
	end
endmodule : urab_usb_model
`default_nettype wire

//--- usb_register_access_bridge_bench.sv
`timescale 1ns/100ps
`default_nettype none
module usb_register_access_bridge_bench;
	import urab_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [5:0] map_addr = 6'h00;
	logic map_wr = 1'b0;
	logic [15:0] map_wdata = 16'h0000;
	logic [7:0] in_irq_set = 8'h00;
	logic [7:0] out_irq_set = 8'h00;
	logic [7:0] bus_irq_set = 8'h00;
	logic [10:0] frame_number = 11'h5A3;
	logic [12:0] out_rx_count = 13'h1ABC;
	logic [15:0] reg_rdata, map_rdata, usb_fifo_wdata, usb_fifo_rdata, wr_last, v;
	logic usb_fifo_wr, usb_fifo_rd, usb_fifo_has_data;
	logic [1:0] usb_fifo_ep;
	logic [3:0] wr_count, rd_count;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	always #2 clk_sys = ~clk_sys;
	urab_bridge urab_bridge_i (.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.map_addr, .map_wr, .map_wdata, .map_rdata, .in_irq_set, .out_irq_set, .bus_irq_set, .frame_number,
		.out_rx_count, .usb_fifo_wr, .usb_fifo_wdata, .usb_fifo_rd, .usb_fifo_rdata, .usb_fifo_has_data,
		.usb_fifo_ep);
	urab_usb_model urab_usb_model_i (.clk_sys, .sys_rst, .usb_fifo_wr, .usb_fifo_wdata, .usb_fifo_rd,
		.usb_fifo_rdata, .usb_fifo_has_data, .wr_count, .wr_last, .rd_count);
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	// A hang shows up as a mismatch rather than a silent stall
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic rw(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : rw
	task automatic rr(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		@(posedge clk_sys);
		#1 d = reg_rdata;
	endtask : rr
	task automatic mw(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		map_addr <= a;
		map_wdata <= d;
		map_wr <= 1'b1;
		@(posedge clk_sys);
		map_wr <= 1'b0;
	endtask : mw
	task automatic mr(input logic [5:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		map_addr <= a;
		@(posedge clk_sys);
		#1 d = map_rdata;
	endtask : mr
	task automatic wait_idle;
		for (int i = 0; i < 20; i++) begin
			rr(URAB_IDX_STAT, v);
			if (v[URAB_STAT_CP_BIT] === 1'b0) break;
		end
		check({15'h0000, v[URAB_STAT_CP_BIT]}, 16'h0000);
	endtask : wait_idle
	task automatic t_reset;
		rr(URAB_IDX_CTRL, v); check(v, 16'h02F0);
		rr(URAB_IDX_STAT, v); check(v, 16'h0001);
		rr(URAB_IDX_TARGET, v); check(v, 16'h0000);
		check({14'h0000, usb_fifo_ep}, 16'h0002);
		mr(6'h00, v); check(v, 16'h2000);
		mr(6'h06, v); check(v, 16'h0007);
		mr(6'h08, v); check(v, 16'h0006);
		mr(6'h0A, v); check(v, 16'h0600);
		mr(6'h10, v); check(v, 16'h0000);
		$display("test reset done");
	endtask : t_reset
	task automatic t_lanes;
		mw(6'h10, 16'h0201);
		mr(6'h10, v); check(v, 16'h0201);
		mr(6'h11, v); check(v, 16'h0002);
		mw(6'h02, 16'h00FF);
		mr(6'h02, v); check(v, 16'h0000);
		@(posedge clk_sys);
		in_irq_set <= 8'h05;
		out_irq_set <= 8'h06;
		bus_irq_set <= 8'h0F;
		@(posedge clk_sys);
		in_irq_set <= 8'h00;
		out_irq_set <= 8'h00;
		bus_irq_set <= 8'h00;
		mr(6'h02, v); check(v, 16'h0005);
		mr(6'h04, v); check(v, 16'h0006);
		mr(6'h0A, v); check(v, 16'h060F);
		mr(6'h0C, v); check(v, 16'h05A3);
		mr(6'h18, v); check(v, 16'h1ABC);
		rw(URAB_IDX_CTRL, 16'h02F4);
		mr(6'h10, v); check(v, 16'h0001);
		rw(URAB_IDX_CTRL, 16'h02F0);
		$display("test lanes done");
	endtask : t_lanes
	task automatic t_index;
		rw(URAB_IDX_CTRL, 16'h01F0);
		#1 check({14'h0000, usb_fifo_ep}, 16'h0001);
		mr(6'h10, v); check(v, 16'h0000);
		mw(6'h10, 16'h0005);
		rw(URAB_IDX_CTRL, 16'h02F0);
		mr(6'h10, v); check(v, 16'h0201);
		rw(URAB_IDX_CTRL, 16'h01F0);
		mr(6'h10, v); check(v, 16'h0005);
		rw(URAB_IDX_CTRL, 16'h02F0);
		$display("test index done");
	endtask : t_index
	task automatic t_burst_wr;
		rw(URAB_IDX_TARGET, {10'h000, URAB_TA_IN_FIFO});
		rw(URAB_IDX_CTRL, 16'h0203);
		rr(URAB_IDX_CTRL, v); check(v, 16'h0203);
		rr(URAB_IDX_STAT, v); check({15'h0000, v[URAB_STAT_FE_BIT]}, 16'h0001);
		@(posedge clk_sys);
		reg_addr <= URAB_IDX_FIFO;
		reg_wr <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			reg_wdata <= 16'hB000 + 16'(i);
			@(posedge clk_sys);
		end
		reg_wr <= 1'b0;
		reg_addr <= URAB_IDX_STAT;
		@(posedge clk_sys);
		#1 check({15'h0000, reg_rdata[URAB_STAT_CP_BIT]}, 16'h0001);
		wait_idle();
		check({12'h000, wr_count}, 16'h0008);
		check(wr_last, 16'hB007);
		rw(URAB_IDX_CTRL, 16'h0200);
		$display("test burst write done");
	endtask : t_burst_wr
	task automatic t_burst_rd;
		rw(URAB_IDX_TARGET, {10'h000, URAB_TA_OUT_FIFO});
		rw(URAB_IDX_CTRL, 16'h0203);
		rr(URAB_IDX_STAT, v); check({15'h0000, v[URAB_STAT_FE_BIT]}, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			reg_addr <= URAB_IDX_FIFO;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			repeat (2) @(posedge clk_sys);
			#1 check(reg_rdata, 16'hA000 + 16'(i));
		end
		check({12'h000, rd_count}, 16'h0008);
		rr(URAB_IDX_STAT, v); check({15'h0000, v[URAB_STAT_LWR_BIT]}, 16'h0001);
		rw(URAB_IDX_STAT, 16'h0008);
		rr(URAB_IDX_STAT, v); check({15'h0000, v[URAB_STAT_LWR_BIT]}, 16'h0000);
		wait_idle();
		rw(URAB_IDX_CTRL, 16'h0200);
		$display("test burst read done");
	endtask : t_burst_rd
	task automatic t_word_wr;
		rw(URAB_IDX_TARGET, {10'h000, URAB_TA_IN_FIFO});
		rw(URAB_IDX_CTRL, 16'h0201);
		rw(URAB_IDX_FIFO, 16'hC0DE);
		// Target is locked while the word drains
		rw(URAB_IDX_TARGET, {10'h000, URAB_TA_OUT_FIFO});
		rr(URAB_IDX_TARGET, v); check(v, {10'h000, URAB_TA_IN_FIFO});
		wait_idle();
		check({12'h000, wr_count}, 16'h0009);
		check(wr_last, 16'hC0DE);
		rw(URAB_IDX_CTRL, 16'h0200);
		rw(URAB_IDX_FIFO, 16'hDEAD);
		repeat (2) @(posedge clk_sys);
		#1 check({12'h000, wr_count}, 16'h0009);
		$display("test word write done");
	endtask : t_word_wr
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_lanes();
		t_index();
		t_burst_wr();
		t_burst_rd();
		t_word_wr();
		stop_test();
	end
endmodule : usb_register_access_bridge_bench
`default_nettype wire
